// *** crcg_pkg.sv ***
`default_nettype none

package crcg_pkg;
    // polynomial coefficient strings, leading x^N term dropped
    localparam logic [31:0] POLY_CRC8 = 32'h0000_0007;
    localparam logic [31:0] POLY_CRC10 = 32'h0000_0233;
    localparam logic [31:0] POLY_CAN = 32'h0000_4599;
    localparam logic [31:0] POLY_CRC16 = 32'h0000_1005;
    localparam logic [31:0] POLY_CRC16INV = 32'h0000_4003;
    localparam logic [31:0] POLY_X25 = 32'h0000_1021;
    localparam logic [31:0] POLY_CRC32 = 32'h04C1_1DB7;
    localparam int MAX_ORDER = 32;
    localparam int MAX_DATA_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [0:0] {
        MODE_PARALLEL = 1'b0,
        MODE_SERIAL = 1'b1
    } crcg_mode_t;
endpackage

`default_nettype wire

// *** crcg_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module crcg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic async_reset_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [AW:0] countNext;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    // flags come from the next count so both handshake outputs leave a flop
    assign countNext = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign outData = mem[rdPtr_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or negedge async_reset_n) begin
        if (!async_reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            // empty in reset; a push before release writes mem[0] but is not counted
            inReady <= 1'b1;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= countNext;
            inReady <= (countNext != (AW+1)'(DEPTH));
            outValid <= (countNext != '0);
        end
    end
endmodule // crcg_fifo

`default_nettype wire

// *** crcg_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module crcg_core #(
    parameter int CRC_W = 16,
    parameter int DATA_W = 8,
    parameter logic [31:0] POLY = crcg_pkg::POLY_X25,
    parameter logic [31:0] INIT = 32'h0000_0000,
    parameter crcg_pkg::crcg_mode_t MODE = crcg_pkg::MODE_PARALLEL,
    parameter int DEPTH = crcg_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // control
    input wire logic sync_init_n,
    input wire logic load,
    // data words from upstream, buffered
    input wire logic dataValid,
    output logic dataReady,
    input wire logic [DATA_W-1:0] dataIn,
    // result
    output logic [CRC_W-1:0] crcOut,
    output logic crcSerOut,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic [crcg_pkg::SYNC_STAGES-1:0] rstSync_q;
    logic async_reset_n;
    logic initMeta_q, initSync_q, loadMeta_q, loadSync_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_q <= '0;
        end else begin
            rstSync_q <= {rstSync_q[crcg_pkg::SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign async_reset_n = rstSync_q[crcg_pkg::SYNC_STAGES-1];

    // control pins come from outside; sampled twice before use
    always_ff @(posedge core_clk or negedge async_reset_n) begin
        if (!async_reset_n) begin
            initMeta_q <= 1'b1;
            initSync_q <= 1'b1;
            loadMeta_q <= 1'b0;
            loadSync_q <= 1'b0;
        end else begin
            initMeta_q <= sync_init_n;
            initSync_q <= initMeta_q;
            loadMeta_q <= load;
            loadSync_q <= loadMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input buffer; it stalls while load is low so words wait, not vanish

    logic fifoValid;
    logic [DATA_W-1:0] fifoData;
    wire take = fifoValid && loadSync_q && initSync_q;

    crcg_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) i_crcg_fifo (
        .clk(core_clk),
        .async_reset_n(async_reset_n),
        .inValid(dataValid),
        .inReady(dataReady),
        .inData(dataIn),
        .outValid(fifoValid),
        .outReady(take),
        .outData(fifoData)
    );

    ////////////////////////////////////////////////////////////////////////
    // CRC arithmetic

    // one bit of polynomial division, MSB-first frame order
    function automatic logic [CRC_W-1:0] crcStep(input logic [CRC_W-1:0] c, input logic d);
        logic fb;
        fb = c[CRC_W-1] ^ d;
        return {c[CRC_W-2:0], 1'b0} ^ (fb ? POLY[CRC_W-1:0] : '0);
    endfunction

    // word step unrolls the bit step; MSB of the word enters first
    function automatic logic [CRC_W-1:0] crcWord(input logic [CRC_W-1:0] c,
                                                 input logic [DATA_W-1:0] d);
        logic [CRC_W-1:0] r;
        r = c;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            r = crcStep(r, d[i]);
        end
        return r;
    endfunction

    logic [CRC_W-1:0] crc_q, crc_d;
    logic [CRC_W-1:0] shift_q;
    logic shiftArmed_q;
    logic [CRC_W-1:0] crcNext;

    // pure combinational path from input and register to register
    assign crcNext = (MODE == crcg_pkg::MODE_SERIAL)
        ? crcStep(crc_q, fifoData[0])
        : crcWord(crc_q, fifoData);

    always_comb begin
        crc_d = crc_q;
        if (!initSync_q) begin
            crc_d = INIT[CRC_W-1:0];
        end else if (take) begin
            crc_d = crcNext;
        end
    end

    // every register here runs on core_clk only
    always_ff @(posedge core_clk or negedge async_reset_n) begin
        if (!async_reset_n) begin
            crc_q <= INIT[CRC_W-1:0];
        end else begin
            crc_q <= crc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial shift-out copy, MSB first; data waits in the buffer while shifting

    wire startShift = (MODE == crcg_pkg::MODE_SERIAL) && !loadSync_q && !shiftArmed_q;

    always_ff @(posedge core_clk or negedge async_reset_n) begin
        if (!async_reset_n) begin
            shift_q <= INIT[CRC_W-1:0];
            shiftArmed_q <= 1'b0;
        end else if (!initSync_q) begin
            shift_q <= INIT[CRC_W-1:0];
            shiftArmed_q <= 1'b0;
        end else if (loadSync_q) begin
            shiftArmed_q <= 1'b0;
        end else if (startShift) begin
            shift_q <= {crc_q[CRC_W-2:0], 1'b0};
            shiftArmed_q <= 1'b1;
        end else begin
            shift_q <= {shift_q[CRC_W-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all registered

    always_ff @(posedge core_clk or negedge async_reset_n) begin
        if (!async_reset_n) begin
            crcOut <= INIT[CRC_W-1:0];
            crcSerOut <= INIT[CRC_W-1];
            busy <= 1'b0;
        end else begin
            crcOut <= crc_d;
            busy <= fifoValid;
            if (startShift) begin
                crcSerOut <= crc_q[CRC_W-1];
            end else if (shiftArmed_q && !loadSync_q) begin
                crcSerOut <= shift_q[CRC_W-1];
            end else begin
                crcSerOut <= crc_d[CRC_W-1];
            end
        end
    end

endmodule // crcg_core

`default_nettype wire

// *** crcg_core_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module crcg_core_chk #(
    parameter int CRC_W = 16,
    parameter logic [31:0] INIT = 32'h0000_0000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // watched
    input wire logic sync_init_n,
    input wire logic load,
    input wire logic dataValid,
    input wire logic dataReady,
    input wire logic [CRC_W-1:0] crcOut,
    input wire logic busy
);
    localparam logic [CRC_W-1:0] PRE = INIT[CRC_W-1:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence idle_s; (!load && sync_init_n)[*5]; endsequence
    sequence init_s; !sync_init_n[*4]; endsequence
    rst_val_a: assert property ($rose(arst_n) |-> crcOut == PRE) else $error("preset");
    rst_busy_a: assert property ($rose(arst_n) |=> !busy) else $error("busy");
    crc_hold_a: assert property (idle_s |-> $stable(crcOut)) else $error("moved");
    init_val_a: assert property (init_s |-> crcOut == PRE) else $error("no init");
    crc_cause_a: assert property ($changed(crcOut) |-> busy ||
        !$past(sync_init_n, 2) || !$past(sync_init_n, 3)) else $error("no cause");
    empty_ready_a: assert property (!busy |-> dataReady) else $error("not ready");
    full_busy_a: assert property (!dataReady |-> busy) else $error("refused");
    push_only_a: assert property ($rose(busy) |-> $past(dataValid, 2)) else $error("no push");
endmodule // crcg_core_chk
bind crcg_core crcg_core_chk #(.CRC_W(CRC_W), .INIT(INIT)) i_crcg_core_chk (
    .core_clk, .arst_n, .sync_init_n, .load, .dataValid, .dataReady, .crcOut, .busy);
`default_nettype wire

// *** crcg_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module crcg_src (
    // clock
    input wire logic core_clk,
    // words to the block
    output logic dataValid,
    input wire logic dataReady,
    output logic [7:0] dataIn
);
    initial dataValid = 1'b0;
    initial dataIn = 8'hA5;
    task automatic send(input logic [7:0] w);
        @(negedge core_clk);
        dataValid = 1'b1;
        dataIn = w;
        do @(posedge core_clk); while (dataReady !== 1'b1);
    endtask
    // flip, never a stale word
    task automatic idle();
        @(negedge core_clk);
        dataValid = 1'b0;
        dataIn = ~dataIn;
    endtask
endmodule // crcg_src
`default_nettype wire

// *** test_configurable_crc_generator.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_configurable_crc_generator;
    logic core_clk = 1'b0, arst_n = 1'b0, sync_init_n = 1'b1, load = 1'b1;
    logic dataValid, dataReady, busy;
    logic [7:0] dataIn;
    logic [15:0] crcOut;
    int num_errors = 0, checked = 0;
    logic serValid = 1'b0, serIn = 1'b0, serReady, serBit, serBusy;
    logic [15:0] serCrc;
    crcg_core i_crcg_core (.core_clk, .arst_n, .sync_init_n, .load, .dataValid, .dataReady,
        .dataIn, .crcOut, .crcSerOut(), .busy);
    crcg_core #(.DATA_W(1), .MODE(crcg_pkg::MODE_SERIAL)) i_crcg_core_ser (.core_clk, .arst_n,
        .sync_init_n, .load, .dataValid(serValid), .dataReady(serReady), .dataIn(serIn),
        .crcOut(serCrc), .crcSerOut(serBit), .busy(serBusy));
    crcg_src i_crcg_src (.core_clk, .dataValid, .dataReady, .dataIn);
    initial forever #5 core_clk = ~core_clk;
    ////////////////
    task automatic check(input string what, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic settle();
        for (int n = 0; n < 100 && (busy !== 1'b0 || serBusy !== 1'b0); n++) @(negedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask
    task automatic t_vector();
        for (int i = 0; i < 9; i++) i_crcg_src.send(8'h31 + 8'(i));
        i_crcg_src.idle();
        settle();
        check("vector", crcOut, 16'h31C3);
    endtask
    task automatic t_hold();
        load = 1'b0;
        repeat (4) @(negedge core_clk);
        for (int i = 0; i < 32; i++) i_crcg_src.send(i == 0 ? 8'h31 : i == 1 ? 8'hC3 : 8'h00);
        i_crcg_src.idle();
        check("full", 16'(dataReady), 16'h0000);
        check("held", crcOut, 16'h31C3);
        load = 1'b1;
        settle();
        check("residue", crcOut, 16'h0000);
    endtask
    task automatic t_init();
        t_vector();
        sync_init_n = 1'b0;
        repeat (5) @(negedge core_clk);
        check("init", crcOut, 16'h0000);
        sync_init_n = 1'b1;
    endtask
    task automatic t_serial();
        logic [7:0] w;
        logic [15:0] e;
        e = 16'h31C3;
        for (int i = 0; i < 72; i++) begin
            w = 8'h31 + 8'(i / 8);
            @(negedge core_clk);
            serValid = 1'b1;
            serIn = w[7 - (i % 8)];
            do @(posedge core_clk); while (serReady !== 1'b1);
        end
        @(negedge core_clk);
        serValid = 1'b0;
        settle();
        check("serial crc", serCrc, e);
        load = 1'b0;
        repeat (3) @(negedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            check("shift out", 16'(serBit), 16'(e[i]));
            @(negedge core_clk);
        end
        check("serial held", serCrc, e);
        load = 1'b1;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        t_vector();
        t_hold();
        t_init();
        t_serial();
        stop_test();
    end
    initial begin
        #20000 num_errors++;
        stop_test();
    end
endmodule // test_configurable_crc_generator
`default_nettype wire
